// ### src/rcsu_byte_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Byte stream with valid and ready
// ****************************************
interface rcsu_byte_if #(parameter int W = 8) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ### src/rcsu_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module rcsu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 300
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic flush,
   rcsu_byte_if.snk  wr,
   rcsu_byte_if.src  rd
);
   import rcsu_pkg::*;

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
   } rcsu_fifo_s;

   rcsu_fifo_s s;
   rcsu_fifo_s next_s;
   logic       wr_go;
   logic       rd_go;

   // Wrap a pointer at the depth, which need not be a power of two
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // Honest flags straight from the count
   assign wr.ready = (s.count != CW'(DEPTH));
   assign rd.valid = (s.count != '0);
   assign rd.data  = s.mem[s.rd_ptr];
   assign wr_go    = wr.valid && wr.ready;
   assign rd_go    = rd.valid && rd.ready;

   // Flush wins over any push or pop in the same cycle
   always_comb begin
      next_s = s;
      if (flush) begin
         next_s.wr_ptr = '0;
         next_s.rd_ptr = '0;
         next_s.count  = '0;
      end else begin
         if (wr_go) begin
            next_s.mem[s.wr_ptr] = wr.data;
            next_s.wr_ptr        = bump(s.wr_ptr);
         end
         if (rd_go) begin
            next_s.rd_ptr = bump(s.rd_ptr);
         end
         next_s.count = s.count + CW'(wr_go) - CW'(rd_go);
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   property p_flush_empties;
      @(posedge clock) disable iff (sys_rst) flush |=> !rd.valid;
   endproperty
   a_flush_empties: assert property (p_flush_empties) else $error("fifo not empty after flush");

endmodule

`default_nettype wire

// ### src/rcsu_pkg.sv
package rcsu_pkg;

   // ****************************************
   // Widths and depths
   // ****************************************
   localparam int          BYTE_W     = 8;
   localparam int          IBUF_DEPTH = 300;
   localparam int          OQ_DEPTH   = 300;
   localparam int          MSG_CNT_W  = 9;

   // ****************************************
   // Characters seen by the byte scanner
   // ****************************************
   localparam logic [7:0]  CHAR_CR    = 8'h0D;
   localparam logic [7:0]  CHAR_LF    = 8'h0A;
   localparam logic [7:0]  CHAR_COLON = 8'h3A;
   localparam logic [7:0]  CHAR_STAR  = 8'h2A;
   localparam logic [7:0]  CHAR_SEMI  = 8'h3B;
   localparam logic [7:0]  CHAR_SPACE = 8'h20;

   // ****************************************
   // Standard event register fields
   // ****************************************
   localparam int          PON_BIT    = 7;
   localparam int          CME_BIT    = 5;
   localparam int          EXE_BIT    = 4;
   localparam int          DDE_BIT    = 3;
   localparam int          QYE_BIT    = 2;
   localparam logic [7:0]  STD_MASK   = 8'hBC;
   localparam logic [7:0]  STD_RESET  = 8'h80;

   // ****************************************
   // Measurement event register fields
   // ****************************************
   localparam int          COMP_BIT   = 7;
   localparam int          RANGE_LSB  = 3;
   localparam int          SAMPLE_BIT = 2;
   localparam int          MEAS_BIT   = 1;
   localparam logic [7:0]  MEAS_MASK  = 8'hFE;
   localparam logic [7:0]  MEAS_RESET = 8'h00;

   // ****************************************
   // Comparator event register fields
   // ****************************************
   localparam int          AND_BIT    = 6;
   localparam int          SECOND_LSB = 3;
   localparam int          FIRST_LSB  = 0;
   localparam int          WITHIN_OFS = 1;
   localparam logic [7:0]  CMP_MASK   = 8'h7F;
   localparam logic [7:0]  CMP_RESET  = 8'h00;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [1:0] {SEL_STD, SEL_MEAS, SEL_CMP, SEL_NONE} rcsu_sel_e;
   typedef enum logic [2:0] {PATH_NONE, PATH_A, PATH_COMP, PATH_B, PATH_RANGE,
                             PATH_USER} rcsu_path_e;
   typedef enum logic {SCAN_UNIT_START, SCAN_IN_UNIT} rcsu_scan_e;

endpackage

// ### src/rcsu_top.sv
// Overview of operation
// - Later compound commands on a line reuse the stored current path as their head.
// - Path clears at reset, at a leading colon, and at each terminator.
// - Asterisk headers ignore the stored path and leave it unchanged.
// - Only six path values exist: none, path_a, comparator, path_b, range, user.
// - Responses queue up and leave the queue as they are sent.
// - Queue holds 300 bytes; overflow raises query error and empties it.
// - Output queue is empty after power returns.
// - Input buffer holds 300 bytes; bytes arriving while full are dropped.
// - Three 8-bit event registers show the unit's state.
// - Each event register clears on clear-status and on its own query; at power-on standard loads only bit 7, the others clear.
// - Standard bit 7 is set at power-on.
// - Standard bit 5 flags command errors.
// - Standard bit 4 flags execution errors.
// - Standard bit 3 flags device errors only when no other error class applies.
// - Standard bit 2 flags queue overflow or lost response data.
// - Measurement bits 7, 2, 1 mark compensation, sampling, measurement done.
// - Measurement bits 6 to 3 flag second and first parameter over and underflow.
// - Comparator bits 0-2 and 3-5 give above, within, below per parameter.
// - Comparator bit 6 is within-first AND within-second.
// - Terminator is CR then LF; no command leaves before its terminator arrives.
// - A header starting with an asterisk is a common command header.
`timescale 1ns/1ps
`default_nettype none

module rcsu_top (
   input  wire logic                clock,
   input  wire logic                sys_rst,
   input  wire logic                rx_valid,
   input  wire logic [7:0]          rx_data,
   output var  logic                rx_ready,
   output var  logic [7:0]          cmd_data,
   output var  logic                cmd_valid,
   input  wire logic                cmd_ready,
   output var  rcsu_pkg::rcsu_path_e current_path,
   output var  logic                common_header,
   input  wire logic                path_load,
   input  wire rcsu_pkg::rcsu_path_e path_group,
   input  wire logic                resp_valid,
   input  wire logic [7:0]          resp_data,
   input  wire logic                resp_lost,
   output var  logic [7:0]          tx_data,
   output var  logic                tx_valid,
   input  wire logic                tx_ready,
   input  wire logic                ev_cmd_err,
   input  wire logic                ev_exe_err,
   input  wire logic                ev_dev_err,
   input  wire logic                ev_comp_done,
   input  wire logic                ev_sample_done,
   input  wire logic                ev_meas_done,
   input  wire logic [3:0]          ev_range,
   input  wire logic                cmp_valid,
   input  wire logic [2:0]          cmp_first,
   input  wire logic [2:0]          cmp_second,
   input  wire logic                status_clear,
   input  wire logic                rd_req,
   input  wire rcsu_pkg::rcsu_sel_e  rd_sel,
   output var  logic [7:0]          rd_data,
   output var  logic                rd_valid
);
   import rcsu_pkg::*;

   // ****************************************
   // State and wiring
   // ****************************************
   typedef struct packed {
      logic [7:0]           cmd_data;
      logic                 cmd_valid;
      rcsu_path_e           path;
      logic                 common;
      rcsu_scan_e           scan;
      logic                 in_cr;
      logic                 out_cr;
      logic [MSG_CNT_W-1:0] msgs;
      logic                 rx_ready;
      logic [7:0]           tx_data;
      logic                 tx_valid;
      logic [7:0]           std_ev;
      logic [7:0]           meas_ev;
      logic [7:0]           cmp_ev;
      logic [7:0]           rd_data;
      logic                 rd_valid;
   } rcsu_top_s;

   rcsu_top_s  s;
   rcsu_top_s  next_s;
   logic       rx_take;
   logic       term_in;
   logic       pop;
   logic       term_out;
   logic       overflow;
   logic       qye_ev;
   logic       other_err;
   logic [7:0] std_set;
   logic [7:0] meas_set;
   logic [7:0] cmp_set;
   logic       clr_std;
   logic       clr_meas;
   logic       clr_cmp;

   rcsu_byte_if #(.W(BYTE_W)) ib_wr ();
   rcsu_byte_if #(.W(BYTE_W)) ib_rd ();
   rcsu_byte_if #(.W(BYTE_W)) oq_wr ();
   rcsu_byte_if #(.W(BYTE_W)) oq_rd ();

   // ****************************************
   // Input buffer
   // ****************************************
   // No stall toward the link: bytes that find it full are lost
   rcsu_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (IBUF_DEPTH)
   ) u_in_buf (
      .clock   (clock),
      .sys_rst (sys_rst),
      .flush   (1'b0),
      .wr      (ib_wr),
      .rd      (ib_rd)
   );

   // Link side feed and terminator count on entry
   assign ib_wr.valid = rx_valid;
   assign ib_wr.data  = rx_data;
   assign rx_take     = rx_valid && ib_wr.ready;
   assign term_in     = rx_take && s.in_cr && (rx_data == CHAR_LF);
   // Drain only while a whole message sits in the buffer
   assign ib_rd.ready = (s.msgs != '0) && (!s.cmd_valid || cmd_ready);
   assign pop         = ib_rd.valid && ib_rd.ready;
   assign term_out    = pop && s.out_cr && (ib_rd.data == CHAR_LF);

   // ****************************************
   // Output queue
   // ****************************************
   rcsu_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (OQ_DEPTH)
   ) u_out_q (
      .clock   (clock),
      .sys_rst (sys_rst),
      .flush   (overflow),
      .wr      (oq_wr),
      .rd      (oq_rd)
   );

   // A byte that does not fit empties the queue instead of stalling
   assign oq_wr.valid = resp_valid;
   assign oq_wr.data  = resp_data;
   assign overflow    = resp_valid && !oq_wr.ready;
   assign oq_rd.ready = !s.tx_valid || tx_ready;

   // ****************************************
   // Event sources
   // ****************************************
   // Device error only counts when no other class fires with it
   assign qye_ev    = overflow || resp_lost;
   assign other_err = ev_cmd_err || ev_exe_err || qye_ev;
   always_comb begin
      std_set                          = '0;
      std_set[CME_BIT]                 = ev_cmd_err;
      std_set[EXE_BIT]                 = ev_exe_err;
      std_set[DDE_BIT]                 = ev_dev_err && !other_err;
      std_set[QYE_BIT]                 = qye_ev;
      meas_set                         = '0;
      meas_set[COMP_BIT]               = ev_comp_done;
      meas_set[RANGE_LSB+3:RANGE_LSB]  = ev_range;
      meas_set[SAMPLE_BIT]             = ev_sample_done;
      meas_set[MEAS_BIT]               = ev_meas_done;
      cmp_set                          = '0;
      if (cmp_valid) begin
         cmp_set[FIRST_LSB+2:FIRST_LSB]   = cmp_first;
         cmp_set[SECOND_LSB+2:SECOND_LSB] = cmp_second;
         cmp_set[AND_BIT] = cmp_first[WITHIN_OFS] && cmp_second[WITHIN_OFS];
      end
   end
   // Query of one register or clear-status empties it
   assign clr_std  = status_clear || (rd_req && rd_sel == SEL_STD);
   assign clr_meas = status_clear || (rd_req && rd_sel == SEL_MEAS);
   assign clr_cmp  = status_clear || (rd_req && rd_sel == SEL_CMP);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      // Buffer room seen by the link, one cycle late
      next_s.rx_ready = ib_wr.ready;
      if (rx_take) begin
         next_s.in_cr = (rx_data == CHAR_CR);
      end
      next_s.msgs = s.msgs + MSG_CNT_W'(term_in) - MSG_CNT_W'(term_out);
      // Command byte stage toward the interpreter
      if (s.cmd_valid && cmd_ready) begin
         next_s.cmd_valid = 1'b0;
      end
      if (pop) begin
         next_s.cmd_data  = ib_rd.data;
         next_s.cmd_valid = 1'b1;
         next_s.out_cr    = (ib_rd.data == CHAR_CR);
      end
      // Header scan: first character of each message unit
      if (pop) begin
         case (s.scan)
            SCAN_UNIT_START: begin
               if (ib_rd.data == CHAR_COLON) begin
                  next_s.path   = PATH_NONE;
                  next_s.common = 1'b0;
                  next_s.scan   = SCAN_IN_UNIT;
               end else if (ib_rd.data == CHAR_STAR) begin
                  next_s.common = 1'b1;
                  next_s.scan   = SCAN_IN_UNIT;
               end else if (ib_rd.data != CHAR_SPACE && ib_rd.data != CHAR_CR
                            && ib_rd.data != CHAR_LF) begin
                  next_s.common = 1'b0;
                  next_s.scan   = SCAN_IN_UNIT;
               end
            end
            SCAN_IN_UNIT: begin
               if (ib_rd.data == CHAR_SEMI) begin
                  next_s.scan = SCAN_UNIT_START;
               end
            end
            default: begin
               next_s.scan = SCAN_UNIT_START;
            end
         endcase
      end
      // Interpreter names the group once a compound head is decoded
      if (path_load && !s.common) begin
         next_s.path = path_group;
      end
      // The terminator ends the message and forgets the path
      if (term_out) begin
         next_s.path   = PATH_NONE;
         next_s.common = 1'b0;
         next_s.scan   = SCAN_UNIT_START;
      end
      // Transmit stage; an overflow discards what is waiting too
      if (s.tx_valid && tx_ready) begin
         next_s.tx_valid = 1'b0;
      end
      if (oq_rd.valid && oq_rd.ready) begin
         next_s.tx_data  = oq_rd.data;
         next_s.tx_valid = 1'b1;
      end
      if (overflow) begin
         next_s.tx_valid = 1'b0;
      end
      // Event registers: a set in the clearing cycle survives
      next_s.std_ev  = ((clr_std ? 8'h00 : s.std_ev) | std_set) & STD_MASK;
      next_s.meas_ev = ((clr_meas ? 8'h00 : s.meas_ev) | meas_set) & MEAS_MASK;
      next_s.cmp_ev  = ((clr_cmp ? 8'h00 : s.cmp_ev) | cmp_set) & CMP_MASK;
      // Query answer shows the value before the clear
      next_s.rd_valid = rd_req;
      if (rd_req) begin
         if (rd_sel == SEL_STD) begin
            next_s.rd_data = s.std_ev;
         end else if (rd_sel == SEL_MEAS) begin
            next_s.rd_data = s.meas_ev;
         end else if (rd_sel == SEL_CMP) begin
            next_s.rd_data = s.cmp_ev;
         end else begin
            next_s.rd_data = 8'h00;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Power-on: queues empty, path cleared, only the power flag set
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s          <= '0;
         s.rx_ready <= 1'b1;
         s.std_ev   <= STD_RESET;
         s.meas_ev  <= MEAS_RESET;
         s.cmp_ev   <= CMP_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign rx_ready      = s.rx_ready;
   assign cmd_data      = s.cmd_data;
   assign cmd_valid     = s.cmd_valid;
   assign current_path  = s.path;
   assign common_header = s.common;
   assign tx_data       = s.tx_data;
   assign tx_valid      = s.tx_valid;
   assign rd_data       = s.rd_data;
   assign rd_valid      = s.rd_valid;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_term_clears;
      term_out |=> (s.path == PATH_NONE) && (s.scan == SCAN_UNIT_START);
   endproperty
   a_term_clears: assert property (p_term_clears) else $error("path kept after terminator");
   property p_colon_clears;
      pop && s.scan == SCAN_UNIT_START && ib_rd.data == CHAR_COLON && !path_load
      |=> s.path == PATH_NONE;
   endproperty
   a_colon_clears: assert property (p_colon_clears) else $error("path kept after colon");
   property p_common_keeps;
      s.common && !term_out && !(pop && s.scan == SCAN_UNIT_START && ib_rd.data == CHAR_COLON)
      |=> s.path == $past(s.path);
   endproperty
   a_common_keeps: assert property (p_common_keeps) else $error("common header moved path");
   property p_relative_load;
      path_load && !s.common && !term_out |=> s.path == $past(path_group);
   endproperty
   a_relative_load: assert property (p_relative_load) else $error("path not loaded");
   property p_wait_terminator;
      s.msgs == '0 |-> !pop;
   endproperty
   a_wait_terminator: assert property (p_wait_terminator) else $error("byte left before terminator");
   property p_overflow_flag;
      overflow |=> s.std_ev[QYE_BIT] && !s.tx_valid && !oq_rd.valid;
   endproperty
   a_overflow_flag: assert property (p_overflow_flag) else $error("overflow not handled");
   property p_sent_leaves;
      s.tx_valid && tx_ready && !oq_rd.valid |=> !s.tx_valid;
   endproperty
   a_sent_leaves: assert property (p_sent_leaves) else $error("sent byte stayed queued");
   property p_full_drops;
      rx_valid && !ib_wr.ready && !pop |=> !ib_wr.ready;
   endproperty
   a_full_drops: assert property (p_full_drops) else $error("full buffer took a byte");
   property p_query_clears;
      rd_req && rd_sel == SEL_MEAS && meas_set == '0
      |=> rd_valid && rd_data == $past(s.meas_ev) && s.meas_ev == 8'h00;
   endproperty
   a_query_clears: assert property (p_query_clears) else $error("query did not clear");
   property p_cmd_err_sets;
      ev_cmd_err |=> s.std_ev[CME_BIT] ##1 (s.std_ev[CME_BIT] || $past(clr_std));
   endproperty
   a_cmd_err_sets: assert property (p_cmd_err_sets) else $error("command error lost");
   property p_dde_suppressed;
      ev_dev_err && ev_exe_err && (clr_std || !s.std_ev[DDE_BIT])
      |=> !s.std_ev[DDE_BIT] && s.std_ev[EXE_BIT];
   endproperty
   a_dde_suppressed: assert property (p_dde_suppressed) else $error("device error not suppressed");
   property p_and_bit;
      s.cmp_ev[AND_BIT] |-> s.cmp_ev[FIRST_LSB+WITHIN_OFS] && s.cmp_ev[SECOND_LSB+WITHIN_OFS];
   endproperty
   a_and_bit: assert property (p_and_bit) else $error("and bit without both within");
   property p_unused_zero;
      (s.std_ev & ~STD_MASK) == 8'h00 && !s.meas_ev[0] && !s.cmp_ev[7];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused event bit set");
   // Main scenarios
   c_overflow:  cover property (overflow);
   c_path_load: cover property (path_load && !s.common ##[1:20] term_out);
   c_std_read:  cover property (rd_req && rd_sel == SEL_STD && s.std_ev != 8'h00);
   c_full_drop: cover property (rx_valid && !ib_wr.ready);

endmodule

`default_nettype wire

// ### verification/rcsu_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Serial host: sends bytes, drains replies
// ****************************************
module rcsu_host_model (
   input  wire logic       clock,
   input  wire logic       stall,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic       tx_ready
);
   logic [7:0] got[$];
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end
   // One strobe per byte; idle data inverted so stale bytes never match
   task automatic send(input logic [7:0] b);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= b;
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
   endtask
   // Slow host holds off the transmitter
   assign tx_ready = ~stall;
   always @(posedge clock) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
      end
   end
endmodule

`default_nettype wire

// ### verification/rcsu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rcsu_top_tb;
   import rcsu_pkg::*;
   typedef struct {logic [17:0] ev; rcsu_sel_e sel; logic [7:0] exp;} rcsu_row_s;
   logic        clock, sys_rst, rx_valid, rx_ready, cmd_valid, cmd_ready, common_header, path_load;
   logic        resp_valid, resp_lost, tx_valid, tx_ready, cmp_valid, status_clear, rd_req, rd_valid, stall;
   logic        ev_cmd_err, ev_exe_err, ev_dev_err, ev_comp_done, ev_sample_done, ev_meas_done;
   logic [7:0]  rx_data, cmd_data, resp_data, tx_data, rd_data;
   logic [2:0]  cmp_first, cmp_second;
   logic [3:0]  ev_range;
   logic [17:0] ev;
   rcsu_path_e  current_path, path_group;
   rcsu_sel_e   rd_sel;
   int          n_mismatch, n_compared;
   logic [7:0]  cmdq[$];
   rcsu_row_s   rows[11] = '{
      '{18'h00001, SEL_STD, 8'h20}, '{18'h00002, SEL_STD, 8'h10}, '{18'h00004, SEL_STD, 8'h08},
      '{18'h00007, SEL_STD, 8'h30}, '{18'h00008, SEL_STD, 8'h04}, '{18'h00010, SEL_MEAS, 8'h80},
      '{18'h00060, SEL_MEAS, 8'h06}, '{18'h00780, SEL_MEAS, 8'h78}, '{18'h12800, SEL_CMP, 8'h52},
      '{18'h21800, SEL_CMP, 8'h21}, '{18'h00000, SEL_NONE, 8'h00}};
   assign {cmp_second, cmp_first, cmp_valid, ev_range, ev_meas_done, ev_sample_done, ev_comp_done,
           resp_lost, ev_dev_err, ev_exe_err, ev_cmd_err} = ev;

   rcsu_top uut (.clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .current_path(current_path), .common_header(common_header), .path_load(path_load),
      .path_group(path_group), .resp_valid(resp_valid), .resp_data(resp_data), .resp_lost(resp_lost),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .ev_cmd_err(ev_cmd_err),
      .ev_exe_err(ev_exe_err), .ev_dev_err(ev_dev_err), .ev_comp_done(ev_comp_done),
      .ev_sample_done(ev_sample_done), .ev_meas_done(ev_meas_done), .ev_range(ev_range),
      .cmp_valid(cmp_valid), .cmp_first(cmp_first), .cmp_second(cmp_second),
      .status_clear(status_clear), .rd_req(rd_req), .rd_sel(rd_sel), .rd_data(rd_data), .rd_valid(rd_valid));
   rcsu_host_model host (.clock(clock), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));

   // ****************************************
   // Clock, command monitor, watchdog
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (cmd_valid && cmd_ready) begin
         cmdq.push_back(cmd_data);
      end
   end
   initial begin
      repeat (100000) @(posedge clock);
      n_mismatch++;
      results();
   end

   task automatic results;
      $display("Counts: compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   // Query answer lands one cycle after the request edge
   task automatic read(input rcsu_sel_e s, input logic [7:0] e);
      @(posedge clock);
      rd_req <= 1'b1;
      rd_sel <= s;
      @(posedge clock);
      rd_req <= 1'b0;
      #1;
      check(rd_valid === 1'b1 && rd_data === e, "register read");
   endtask
   task automatic load(input rcsu_path_e g, input rcsu_path_e e);
      @(posedge clock);
      path_load  <= 1'b1;
      path_group <= g;
      @(posedge clock);
      path_load  <= 1'b0;
      #1;
      check(current_path === e, "current path");
   endtask
   // Wait for the first byte, take exactly one
   task automatic take_one(input logic [7:0] e);
      int i;
      for (i = 0; i < 50 && cmd_valid !== 1'b1; i++) @(posedge clock);
      check(cmd_valid === 1'b1 && cmd_data === e, "command byte");
      @(posedge clock);
      cmd_ready <= 1'b1;
      @(posedge clock);
      cmd_ready <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {sys_rst, cmd_ready, path_load, resp_valid, status_clear, rd_req, stall} = 7'b1000000;
      {ev, resp_data} = '0;
      path_group = PATH_NONE;
      rd_sel = SEL_STD;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      check(rx_ready === 1'b1 && tx_valid === 1'b0 && current_path === PATH_NONE, "reset outputs");
      read(SEL_STD, 8'h80);
      read(SEL_MEAS, 8'h00);
      read(SEL_CMP, 8'h00);
      for (int i = 0; i < 11; i++) begin
         @(posedge clock) ev <= rows[i].ev;
         @(posedge clock) ev <= '0;
         read(rows[i].sel, rows[i].exp);
         read(rows[i].sel, 8'h00);
      end
      @(posedge clock) ev <= 18'h00011;
      @(posedge clock) ev <= '0;
      @(posedge clock) status_clear <= 1'b1;
      @(posedge clock) status_clear <= 1'b0;
      read(SEL_STD, 8'h00);
      read(SEL_MEAS, 8'h00);
      $display("test events done");
      for (int p = 1; p < 6; p++) load(rcsu_path_e'(p), rcsu_path_e'(p));
      load(PATH_A, PATH_A);
      host.send(CHAR_STAR);
      host.send(8'h52);
      host.send(CHAR_CR);
      repeat (4) @(posedge clock);
      check(cmd_valid === 1'b0, "early command");
      host.send(CHAR_LF);
      take_one(CHAR_STAR);
      check(common_header === 1'b1, "common header");
      load(PATH_B, PATH_A);
      cmd_ready <= 1'b1;
      repeat (10) @(posedge clock);
      check(cmdq.size() == 4 && cmdq[3] === CHAR_LF, "byte order");
      check(current_path === PATH_NONE && common_header === 1'b0, "path after end");
      cmd_ready <= 1'b0;
      load(PATH_COMP, PATH_COMP);
      host.send(CHAR_COLON);
      host.send(8'h4B);
      host.send(CHAR_CR);
      host.send(CHAR_LF);
      take_one(CHAR_COLON);
      check(current_path === PATH_NONE, "colon clears path");
      cmd_ready <= 1'b1;
      repeat (10) @(posedge clock);
      $display("test path done");
      cmdq.delete();
      cmd_ready <= 1'b0;
      repeat (298) host.send(8'h41);
      host.send(CHAR_CR);
      host.send(CHAR_LF);
      repeat (3) host.send(8'h5A);
      check(rx_ready === 1'b0, "buffer full");
      cmd_ready <= 1'b1;
      repeat (320) @(posedge clock);
      check(cmdq.size() == 300 && cmdq[299] === CHAR_LF, "dropped bytes");
      host.send(CHAR_CR);
      host.send(CHAR_LF);
      repeat (8) @(posedge clock);
      check(cmdq.size() == 303 && cmdq[300] === 8'h5A, "one byte after full");
      $display("test input buffer done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         resp_valid <= 1'b1;
         resp_data  <= 8'h4F + 8'(i);
      end
      @(posedge clock) resp_valid <= 1'b0;
      repeat (10) @(posedge clock);
      check(host.got.size() == 2 && host.got[0] === 8'h4F && host.got[1] === 8'h50, "queue order");
      stall <= 1'b1;
      for (int i = 0; i < 302; i++) begin
         @(posedge clock);
         resp_valid <= 1'b1;
         resp_data  <= 8'(i);
      end
      @(posedge clock) resp_valid <= 1'b0;
      repeat (3) @(posedge clock);
      check(tx_valid === 1'b0, "overflow flush");
      read(SEL_STD, 8'h04);
      stall <= 1'b0;
      repeat (5) @(posedge clock);
      check(host.got.size() == 2, "queue emptied");
      stall <= 1'b1;
      @(posedge clock) resp_valid <= 1'b1;
      @(posedge clock) resp_valid <= 1'b0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      stall   <= 1'b0;
      repeat (5) @(posedge clock);
      check(host.got.size() == 2 && tx_valid === 1'b0, "queue after power");
      read(SEL_STD, 8'h80);
      $display("test output queue done");
      results();
   end
endmodule

`default_nettype wire
